//--- hdl/eeprom_host.sv
// host controller driving a byte-wide eeprom over its strobes
`timescale 1ns/10ps
`include "eeprom_host_map.svh"

// How it works
// - chip select low only during an access
// - write: chip and write low, output high
// - page holds one to 128 bytes
// - page bits six up stay fixed
// - next byte within 75 us of previous
module eeprom_host
   import eeprom_host_pkg::*;
#(
   parameter int PROG_MAX_CYC = `PROG_MAX_CYC,
   parameter int BYTE_LOAD_CYC = `BYTE_LOAD_CYC
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic req_last_i,
   input wire logic [`ADDR_W-1:0] req_addr_i,
   input wire logic [`DATA_W-1:0] req_wdata_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [`DATA_W-1:0] rsp_rdata_o,
   output logic prog_timeout_o,
   output logic busy_o,
   output logic [`ADDR_W-1:0] byte_address_o,
   output logic chip_sel_n_o,
   output logic out_en_n_o,
   output logic write_en_n_o,
   input wire logic [`DATA_W-1:0] data_bus_i,
   output logic [`DATA_W-1:0] data_bus_o,
   output logic data_bus_oe_o
);

   // =====================================================
   // state
   host_state_t state_reg, state_next;
   logic [22:0] cnt_reg, cnt_next;
   logic [22:0] gap_reg, gap_next;
   logic [7:0] page_cnt_reg, page_cnt_next;
   logic [`ADDR_W-1:0] addr_reg, addr_next;
   logic [`DATA_W-1:0] wdata_reg, wdata_next;
   logic [`DATA_W-1:0] rdata_reg, rdata_next;
   logic rsp_reg, rsp_next;
   logic tmo_reg, tmo_next;
   logic [`ADDR_W-1:`PAGE_LSB] page_reg, page_next;
   // high for one cycle after the write strobe rises
   logic wr_hold_reg;

   // =====================================================
   // decode
   wire strobe_done = (cnt_reg == 23'(`STROBE_CYC - 1));
   wire idle_accept = (state_reg == ST_IDLE) && req_valid_i;
   wire gap_accept = (state_reg == ST_WR_GAP) && req_valid_i && req_write_i
      && (req_addr_i[`ADDR_W-1:`PAGE_LSB] == page_reg)
      && (page_cnt_reg < 8'(`PAGE_BYTES));
   wire gap_expired = (gap_reg >= 23'(BYTE_LOAD_CYC - 1));
   wire poll_match = (data_bus_i[`POLL_BIT] == wdata_reg[`POLL_BIT]);
   wire write_phase = (state_reg == ST_WR_LOW);
   wire read_phase = (state_reg == ST_RD_LOW) || (state_reg == ST_POLL_LOW);

   assign req_ready_o = (state_reg == ST_IDLE) || gap_accept;
   assign busy_o = (state_reg != ST_IDLE);
   assign rsp_valid_o = rsp_reg;
   assign rsp_rdata_o = rdata_reg;
   assign prog_timeout_o = tmo_reg;
   // die select bits pass untouched along with the rest of the address
   assign byte_address_o = addr_reg;
   assign chip_sel_n_o = !(write_phase || read_phase);
   assign out_en_n_o = !read_phase;
   assign write_en_n_o = !write_phase;
   assign data_bus_o = wdata_reg;
   // data stays driven one cycle past the rising strobe, so the device
   // latches settled data rather than a bus that is already turning round
   assign data_bus_oe_o = !(write_phase || wr_hold_reg);

   // =====================================================
   // next state
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      gap_next = gap_reg;
      page_cnt_next = page_cnt_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      page_next = page_reg;
      rsp_next = 1'b0;
      tmo_next = tmo_reg;
      unique case (state_reg)
         ST_IDLE: begin
            cnt_next = '0;
            if (idle_accept) begin
               addr_next = req_addr_i;
               wdata_next = req_wdata_i;
               page_next = req_addr_i[`ADDR_W-1:`PAGE_LSB];
               tmo_next = 1'b0;
               page_cnt_next = 8'h01;
               gap_next = '0;
               state_next = req_write_i ? ST_WR_LOW : ST_RD_LOW;
            end
         end
         ST_RD_LOW: begin
            cnt_next = cnt_reg + 23'h1;
            if (strobe_done) begin
               rdata_next = data_bus_i;
               rsp_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_WR_LOW: begin
            cnt_next = cnt_reg + 23'h1;
            gap_next = gap_reg + 23'h1;
            if (strobe_done) begin
               cnt_next = '0;
               state_next = ST_WR_GAP;
            end
         end
         ST_WR_GAP: begin
            gap_next = gap_reg + 23'h1;
            if (gap_accept) begin
               addr_next = req_addr_i;
               wdata_next = req_wdata_i;
               page_cnt_next = page_cnt_reg + 8'h01;
               gap_next = '0;
               state_next = ST_WR_LOW;
            end else if (gap_expired || req_last_i ||
                         page_cnt_reg == 8'(`PAGE_BYTES)) begin
               cnt_next = '0;
               state_next = ST_POLL_GAP;
            end
         end
         ST_POLL_GAP: begin
            cnt_next = cnt_reg + 23'h1;
            if (cnt_reg >= 23'(PROG_MAX_CYC)) begin
               tmo_next = 1'b1;
               state_next = ST_DONE;
            end else if (cnt_reg[1:0] == 2'h3) begin
               state_next = ST_POLL_LOW;
            end
         end
         ST_POLL_LOW: begin
            cnt_next = cnt_reg + 23'h1;
            if (cnt_reg[1:0] == 2'h3) begin
               state_next = poll_match ? ST_DONE : ST_POLL_GAP;
            end
         end
         ST_DONE: begin
            rsp_next = 1'b1;
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // =====================================================
   // registers
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
         gap_reg <= '0;
         page_cnt_reg <= '0;
         addr_reg <= '0;
         wdata_reg <= '0;
         rdata_reg <= '0;
         page_reg <= '0;
         rsp_reg <= 1'b0;
         tmo_reg <= 1'b0;
         wr_hold_reg <= 1'b0;
      end else if (clk_en_i) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         gap_reg <= gap_next;
         page_cnt_reg <= page_cnt_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         page_reg <= page_next;
         rsp_reg <= rsp_next;
         tmo_reg <= tmo_next;
         wr_hold_reg <= write_phase;
      end
   end

   // =====================================================
   // checks
   no_oe_write_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      !write_en_n_o |-> out_en_n_o && !chip_sel_n_o)
      else $error("write strobe with output enable low");
   bus_release_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      !out_en_n_o |-> data_bus_oe_o)
      else $error("host drives bus during read");
   cs_idle_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == ST_IDLE) |-> chip_sel_n_o)
      else $error("chip select low while idle");
   page_same_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(write_en_n_o) && $past(state_reg) == ST_WR_GAP
      |-> byte_address_o[`ADDR_W-1:`PAGE_LSB] == page_reg)
      else $error("page address changed inside page");
   page_len_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      page_cnt_reg <= 8'(`PAGE_BYTES))
      else $error("page longer than allowed");
   gap_bound_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      state_reg == ST_WR_GAP |-> gap_reg < 23'(BYTE_LOAD_CYC))
      else $error("byte load gap too long");
   wdata_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      clk_en_i && !write_en_n_o && $past(!write_en_n_o) |-> $stable(data_bus_o))
      else $error("write data moved during strobe");
   data_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $rose(write_en_n_o) |-> !data_bus_oe_o && $stable(data_bus_o))
      else $error("write data released with strobe");
   addr_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      !chip_sel_n_o && $past(!chip_sel_n_o) |-> $stable(byte_address_o))
      else $error("address moved during strobe");

endmodule : eeprom_host

//--- hdl/eeprom_host_map.svh
// constants for the byte-wide eeprom host controller
`ifndef EEPROM_HOST_MAP_SVH
`define EEPROM_HOST_MAP_SVH
`define CLK_MHZ 40
`define ADDR_W 17
`define DATA_W 8
`define PAGE_BYTES 128
`define PAGE_LSB 6
`define BYTE_LOAD_US 100
`define BYTE_LOAD_CYC ((`BYTE_LOAD_US * `CLK_MHZ) * 3 / 4)
`define PROG_MAX_MS 5
`define PROG_MAX_CYC (`PROG_MAX_MS * 1000 * `CLK_MHZ)
`define STROBE_CYC 4
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define DIE_SEL_LSB 15
`endif

//--- hdl/eeprom_host_pkg.sv
// types for the byte-wide eeprom host controller
package eeprom_host_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_LOW,
      ST_WR_LOW,
      ST_WR_GAP,
      ST_POLL_LOW,
      ST_POLL_GAP,
      ST_DONE
   } host_state_t;
endpackage : eeprom_host_pkg

//--- verif/eeprom_host_tb_top.sv
// self-checking bench for the eeprom host controller
`timescale 1ns/10ps
module eeprom_host_tb_top;
   // =====
   // clock, design and device
   logic sys_clk_i = 0;
   logic nrst_i = 0;
   logic req_valid_i = 0;
   logic req_write_i = 0;
   logic req_last_i = 0;
   logic lock = 0;
   logic clk_en = 1;
   logic [16:0] req_addr_i = '0;
   logic [7:0] req_wdata_i = '0;
   logic req_ready_o, rsp_valid_o, prog_timeout_o, busy_o, chip_sel_n_o, out_en_n_o;
   logic write_en_n_o, data_bus_oe_o;
   logic [7:0] rsp_rdata_o, data_bus_o, dev_q;
   logic [16:0] byte_address_o;
   int error_cnt = 0;
   int checks = 0;
   int viol;
   wire [7:0] bus = data_bus_oe_o ? dev_q : data_bus_o;
   initial forever #12.5 sys_clk_i = ~sys_clk_i;
   eeprom_host #(.PROG_MAX_CYC(400), .BYTE_LOAD_CYC(50)) DUT (.sys_clk_i, .nrst_i,
      .clk_en_i(clk_en), .req_valid_i, .req_write_i, .req_last_i, .req_addr_i, .req_wdata_i,
      .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .prog_timeout_o, .busy_o, .byte_address_o,
      .chip_sel_n_o, .out_en_n_o, .write_en_n_o, .data_bus_i(bus), .data_bus_o, .data_bus_oe_o);
   eeprom_model #(.LOAD_NS(1500), .PROG_NS(3000)) partner (.a_i(byte_address_o),
      .cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o), .we_n_i(write_en_n_o), .lock_i(lock),
      .d_i(bus), .d_o(dev_q), .viol_o(viol));
   // =====
   // shared tasks
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic req(logic w, logic [16:0] a, logic [7:0] d, logic last);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      req_valid_i <= 1;
      req_write_i <= w;
      req_addr_i <= a;
      req_wdata_i <= d;
      req_last_i <= last;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (req_ready_o !== 1'b1 && n < 2000);
      chk("request taken", 8'h01, {7'h00, req_ready_o});
      req_valid_i <= 0;
   endtask : req
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (busy_o !== 1'b0 && n < 2000);
      chk("response valid", 8'h01, {7'h00, rsp_valid_o});
      req_last_i <= 0;
   endtask : wait_idle
   task automatic rd(logic [16:0] a, logic [7:0] exp);
      req(0, a, 8'h00, 0);
      wait_idle();
      chk("read data", exp, rsp_rdata_o);
   endtask : rd
   // =====
   // scenarios
   task automatic s_byte();
      req(1, 17'h01234, 8'hda, 1);
      wait_idle();
      req(1, 17'h1ffff, 8'ha5, 1);
      wait_idle();
      req(1, 17'h0a5a5, 8'h9b, 1);
      wait_idle();
      rd(17'h01234, 8'hda);
      rd(17'h1ffff, 8'ha5);
      rd(17'h0a5a5, 8'h9b);
   endtask : s_byte
   task automatic s_freeze();
      req(0, 17'h01234, 8'h00, 0);
      clk_en <= 0;
      repeat (6) @(posedge sys_clk_i);
      chk("frozen read strobe", 8'h00, {7'h00, out_en_n_o});
      chk("frozen busy", 8'h01, {7'h00, busy_o});
      clk_en <= 1;
      wait_idle();
      chk("read data", 8'hda, rsp_rdata_o);
   endtask : s_freeze
   task automatic s_page();
      req(1, 17'h00840, 8'h81, 0);
      req(1, 17'h00841, 8'h92, 0);
      req(1, 17'h00842, 8'ha3, 1);
      wait_idle();
      chk("timeout flag", 8'h00, {7'h00, prog_timeout_o});
      rd(17'h00840, 8'h81);
      rd(17'h00842, 8'ha3);
   endtask : s_page
   task automatic s_gap();
      req(1, 17'h00900, 8'h8c, 0);
      wait_idle();
      rd(17'h00900, 8'h8c);
   endtask : s_gap
   task automatic s_lock();
      lock <= 1;
      req(1, 17'h02000, 8'h81, 1);
      wait_idle();
      chk("timeout flag", 8'h01, {7'h00, prog_timeout_o});
      lock <= 0;
      rd(17'h02000, 8'h00);
   endtask : s_lock
   task automatic print_verdict();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (8) @(posedge sys_clk_i);
      nrst_i <= 1;
      @(posedge sys_clk_i);
      s_byte();
      s_freeze();
      s_page();
      s_gap();
      s_lock();
      chk("pin protocol", 8'h00, 8'(viol));
      print_verdict();
   end
   initial begin
      #(20000 * 25);
      error_cnt++;
      print_verdict();
   end
endmodule : eeprom_host_tb_top

//--- verif/eeprom_model.sv
// behavioural byte-wide eeprom answering the host controller
`timescale 1ns/10ps
module eeprom_model #(
   parameter int LOAD_NS = 100000,
   parameter int PROG_NS = 5000000
) (
   input wire logic [16:0] a_i,
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic lock_i,
   input wire logic [7:0] d_i,
   output logic [7:0] d_o,
   output int viol_o
);
   // =====
   // storage, page buffer and status
   logic [7:0] mem [0:131071] = '{default: 8'h00};
   logic [7:0] pend [int];
   logic [16:0] wa = '0;
   logic [16:0] last_a = '0;
   logic [7:0] last_d = '0;
   logic [7:0] held = '0;
   logic [7:0] rv;
   logic loading = 0;
   logic prog = 0;
   logic tog = 0;
   realtime t_wr = 0;
   wire wr = !cs_n_i && !we_n_i && oe_n_i;
   wire rd = !cs_n_i && !oe_n_i;
   initial viol_o = 0;
   assign rv = (prog && a_i == last_a) ? {~last_d[7], tog, mem[a_i][5:0]} : mem[a_i];
   // released bus shows the inverse of the last value driven
   assign d_o = rd ? rv : ~held;
   always @(rd or rv) if (rd) held = rv;
   always @(posedge rd) if (prog) tog = ~tog;
   // address is taken a moment after the falling strobe, once it has settled
   always @(posedge wr) begin
      t_wr = $realtime;
      #1;
      wa = a_i;
      if (prog || (loading && wa[16:6] != last_a[16:6])) viol_o++;
   end
   // locked part ignores plain writes and shows no polling
   always @(negedge wr) if (!lock_i) begin
      pend[wa] = d_i;
      last_a = wa;
      last_d = d_i;
      loading = 1;
   end
   always #100 if (loading && $realtime - t_wr > LOAD_NS) begin
      loading = 0;
      prog = 1;
      #(PROG_NS);
      foreach (pend[i]) mem[i] = pend[i];
      pend.delete();
      prog = 0;
   end
   always @(negedge we_n_i) if (!oe_n_i && !cs_n_i) viol_o++;
endmodule : eeprom_model
